/* include/pwmcc_pkg.sv */
/*
 pwmcc_pkg: register offsets, field positions, reset values and types for the
 pulse counter control block.
 assumes: Avalon-MM byte addresses, 32-bit data words.
*/
`default_nettype none
package pwmcc_pkg;
    localparam logic [11:0] ADDR_IRQ_MASK_SET   = 12'h304;
    localparam logic [11:0] ADDR_IRQ_MASK_CLEAR = 12'h308;
    localparam logic [11:0] ADDR_MODULE_ON      = 12'h500;
    localparam logic [11:0] ADDR_COUNT_DIR_SEL  = 12'h504;
    localparam logic [11:0] ADDR_WRAP_LIMIT     = 12'h508;
    localparam logic [11:0] ADDR_DECODER_LOAD   = 12'h510;
    localparam logic [11:0] ADDR_IRQ_STATUS     = 12'h520;
    localparam logic [11:0] ADDR_PULSE_COUNT    = 12'h524;
    localparam logic [11:0] ADDR_WAVE_TOP       = 12'h528;

    localparam int IRQ_LSB     = 1;
    localparam int IRQ_WIDTH   = 7;
    localparam int BIT_HALT    = 1;
    localparam int BIT_SEQBEG0 = 2;
    localparam int BIT_SEQBEG1 = 3;
    localparam int BIT_SEQFIN0 = 4;
    localparam int BIT_SEQFIN1 = 5;
    localparam int BIT_PERIOD  = 6;
    localparam int BIT_LOOPS   = 7;

    localparam int CNT_WIDTH = 15;

    localparam logic [IRQ_WIDTH-1:0] RST_IRQ_MASK   = 7'h00;
    localparam logic                 RST_MODULE_ON  = 1'h0;
    localparam logic                 RST_COUNT_DIR  = 1'h0;
    localparam logic [CNT_WIDTH-1:0] RST_WRAP_LIMIT = 15'h03FF;
    localparam logic [1:0]           RST_DECODER    = 2'h0;

    localparam logic       DIR_UP          = 1'h0;
    localparam logic       DIR_UP_DOWN     = 1'h1;
    localparam logic [1:0] LOAD_FOUR_SLOT  = 2'h3;

    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ_ANS,
        BUS_WRITE_ANS
    } pwmcc_bus_t;
endpackage : pwmcc_pkg
`default_nettype wire

/* hdl/pwmcc_counter.sv */
/*
 pwmcc_counter: the 15-bit pulse counter, up or up-down, with wrap limit.
 assumes: top value and direction are steady while enabled; tick is a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module pwmcc_counter
    import pwmcc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 runEn,
    input  wire logic                 tick,
    input  wire logic                 countDirection,
    input  wire logic [CNT_WIDTH-1:0] topValue,
    output logic      [CNT_WIDTH-1:0] count,
    output logic                      periodBoundaryEvent
);
    logic [CNT_WIDTH-1:0] count_ff;
    logic                 goingDown_ff;
    logic                 period_ff;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_ff     <= '0;
            goingDown_ff <= 1'b0;
            period_ff    <= 1'b0;
        end
        else if (!runEn)
        begin
            count_ff     <= '0;
            goingDown_ff <= 1'b0;
            period_ff    <= 1'b0;
        end
        else
        begin
            period_ff <= 1'b0;
            if (tick)
            begin
                if (countDirection == DIR_UP)
                begin
                    // edge aligned: wrap to zero at top
                    if (count_ff >= topValue)
                    begin
                        count_ff  <= '0; // [R06] [R10]
                        period_ff <= 1'b1; // [R10]
                    end
                    else
                    begin
                        count_ff <= count_ff + 15'h0001;
                    end
                    goingDown_ff <= 1'b0;
                end
                else if (!goingDown_ff)
                begin
                    // centre aligned: turn round at top
                    if (count_ff >= topValue)
                    begin
                        goingDown_ff <= 1'b1; // [R07]
                        count_ff     <= (count_ff == 15'h0000) ? 15'h0000 : count_ff - 15'h0001;
                    end
                    else
                    begin
                        count_ff <= count_ff + 15'h0001;
                    end
                end
                else
                begin
                    if (count_ff <= 15'h0001)
                    begin
                        count_ff     <= '0; // [R07]
                        goingDown_ff <= 1'b0;
                        period_ff    <= 1'b1; // [R10]
                    end
                    else
                    begin
                        count_ff <= count_ff - 15'h0001;
                    end
                end
            end
        end
    end

    assign count               = count_ff;
    assign periodBoundaryEvent = period_ff;
endmodule : pwmcc_counter
`default_nettype wire

/* hdl/pwmcc_top.sv */
/*
 pwmcc_top: control registers of the pulse width unit, interrupt enables,
 sticky event flags, and the pulse counter.
 assumes: sequence decoder outside drives event pulses and the four-slot top
 value; one 10 MHz clock; Avalon-MM master as sole register client.
*/
// Added by the designer: register access over Avalon-MM.
// How it works
// [R01] a one written to bit 1 of the clear register disables the halt interrupt, zero does nothing, reads show enable.
// [R02] bits 2 and 3 disable the sequence-begun interrupts for sequences 0 and 1 and read back their enables.
// [R03] bits 4 and 5 disable the sequence-finished interrupts for sequences 0 and 1 and read back their enables.
// [R04] bits 6 and 7 disable the period-boundary and loop-exhausted interrupts and read back their enables.
// [R05] bit 0 of the module-on register switches the whole unit on, resetting to off; the code gates only the counter with it and drives the moduleOn port.
// [R06] direction zero, the reset value, counts upward only for edge-aligned pulses.
// [R07] direction one counts up to the top and back down for centre-aligned pulses.
// [R08] a 15-bit wrap limit register, reset to 1023, sets the top of the counter.
// [R09] in four-slot decoder load mode the fourth half-word is the top and the register is ignored.
// [R10] the period-boundary event fires at wrap in up mode and at the return to zero in up-down mode.
`timescale 1ns/1ps
`default_nettype none
module pwmcc_top
    import pwmcc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [11:0]          avsAddress,
    input  wire logic                 avsRead,
    input  wire logic                 avsWrite,
    input  wire logic [31:0]          avsWriteData,
    input  wire logic [3:0]           avsByteEnable,
    output logic      [31:0]          avsReadData,
    output logic                      avsWaitRequest,
    input  wire logic                 countTick,
    input  wire logic                 haltDoneEvent,
    input  wire logic [1:0]           sequenceBegunEvent,
    input  wire logic [1:0]           sequenceFinishedEvent,
    input  wire logic                 loopCountExhaustedEvent,
    input  wire logic [CNT_WIDTH-1:0] waveTopValue,
    output logic                      moduleOn,
    output logic                      countDirection,
    output logic [1:0]                decoderLoad,
    output logic [CNT_WIDTH-1:0]      pulseCount,
    output logic                      periodBoundaryEvent,
    output logic                      irq
);
    pwmcc_bus_t           busState_ff;
    logic [31:0]          readData_ff;
    logic [IRQ_WIDTH-1:0] irqMask_ff;
    logic [IRQ_WIDTH-1:0] irqStatus_ff;
    logic                 moduleOn_ff;
    logic                 countDir_ff;
    logic [CNT_WIDTH-1:0] wrapLimit_ff;
    logic [1:0]           decoderLoad_ff;
    logic [11:0]          addr_ff;
    logic [31:0]          wdata_ff;
    logic [3:0]           be_ff;
    logic                 wrStrobe;
    logic [IRQ_WIDTH-1:0] eventVec;
    logic [CNT_WIDTH-1:0] activeTop;
    logic                 periodPulse;

    function automatic logic hitAddr(input logic [11:0] a, input logic [11:0] target);
        hitAddr = (a[11:2] == target[11:2]);
    endfunction : hitAddr

    ////////////////////////////////////////////////////////////////////////
    // two-cycle slave: capture, then answer with waitrequest low
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busState_ff <= BUS_IDLE;
            addr_ff     <= 12'h000;
            wdata_ff    <= 32'h00000000;
            be_ff       <= 4'h0;
        end
        else
        begin
            case (busState_ff)
                BUS_IDLE:
                begin
                    addr_ff  <= avsAddress;
                    wdata_ff <= avsWriteData;
                    be_ff    <= avsByteEnable;
                    if (avsWrite)
                        busState_ff <= BUS_WRITE_ANS;
                    else if (avsRead)
                        busState_ff <= BUS_READ_ANS;
                end
                default:
                begin
                    busState_ff <= BUS_IDLE;
                end
            endcase
        end
    end

    assign avsWaitRequest = (busState_ff == BUS_IDLE);
    assign wrStrobe       = (busState_ff == BUS_WRITE_ANS);

    ////////////////////////////////////////////////////////////////////////
    // interrupt enables: set and clear views of one register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqMask_ff <= RST_IRQ_MASK;
        end
        else if (wrStrobe && be_ff[0])
        begin
            if (hitAddr(addr_ff, ADDR_IRQ_MASK_CLEAR))
                irqMask_ff <= irqMask_ff & ~wdata_ff[IRQ_LSB +: IRQ_WIDTH]; // [R01] [R02] [R03] [R04]
            else if (hitAddr(addr_ff, ADDR_IRQ_MASK_SET))
                irqMask_ff <= irqMask_ff | wdata_ff[IRQ_LSB +: IRQ_WIDTH];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky event flags, set wins over a write-one clear
    assign eventVec = {loopCountExhaustedEvent, periodPulse, sequenceFinishedEvent,
                       sequenceBegunEvent, haltDoneEvent};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqStatus_ff <= '0;
        end
        else
        begin
            if (wrStrobe && be_ff[0] && hitAddr(addr_ff, ADDR_IRQ_STATUS))
                irqStatus_ff <= (irqStatus_ff & ~wdata_ff[IRQ_LSB +: IRQ_WIDTH]) | eventVec;
            else
                irqStatus_ff <= irqStatus_ff | eventVec;
        end
    end

    assign irq = |(irqStatus_ff & irqMask_ff);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            moduleOn_ff    <= RST_MODULE_ON; // [R05]
            countDir_ff    <= RST_COUNT_DIR; // [R06]
            wrapLimit_ff   <= RST_WRAP_LIMIT; // [R08]
            decoderLoad_ff <= RST_DECODER;
        end
        else if (wrStrobe)
        begin
            if (hitAddr(addr_ff, ADDR_MODULE_ON))
            begin
                if (be_ff[0])
                    moduleOn_ff <= wdata_ff[0]; // [R05]
            end
            else if (hitAddr(addr_ff, ADDR_COUNT_DIR_SEL))
            begin
                if (be_ff[0])
                    countDir_ff <= wdata_ff[0]; // [R06] [R07]
            end
            else if (hitAddr(addr_ff, ADDR_WRAP_LIMIT))
            begin
                // byte lanes honoured; bit 15 and above not stored
                if (be_ff[0])
                    wrapLimit_ff[7:0] <= wdata_ff[7:0]; // [R08]
                if (be_ff[1])
                    wrapLimit_ff[14:8] <= wdata_ff[14:8]; // [R08]
            end
            else if (hitAddr(addr_ff, ADDR_DECODER_LOAD))
            begin
                if (be_ff[0])
                    decoderLoad_ff <= wdata_ff[1:0];
            end
        end
    end

    // four-slot load takes its top from the sequence, not the register
    assign activeTop = (decoderLoad_ff == LOAD_FOUR_SLOT) ? waveTopValue : wrapLimit_ff; // [R09]

    ////////////////////////////////////////////////////////////////////////
    // read data register, unmapped reads return zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            readData_ff <= 32'h00000000;
        end
        else if (busState_ff == BUS_IDLE && avsRead && !avsWrite)
        begin
            if (hitAddr(avsAddress, ADDR_IRQ_MASK_SET) || hitAddr(avsAddress, ADDR_IRQ_MASK_CLEAR))
                readData_ff <= {24'h000000, irqMask_ff, 1'b0}; // [R01] [R02] [R03] [R04]
            else if (hitAddr(avsAddress, ADDR_IRQ_STATUS))
                readData_ff <= {24'h000000, irqStatus_ff, 1'b0};
            else if (hitAddr(avsAddress, ADDR_MODULE_ON))
                readData_ff <= {31'h00000000, moduleOn_ff};
            else if (hitAddr(avsAddress, ADDR_COUNT_DIR_SEL))
                readData_ff <= {31'h00000000, countDir_ff};
            else if (hitAddr(avsAddress, ADDR_WRAP_LIMIT))
                readData_ff <= {17'h00000, wrapLimit_ff};
            else if (hitAddr(avsAddress, ADDR_DECODER_LOAD))
                readData_ff <= {30'h00000000, decoderLoad_ff};
            else if (hitAddr(avsAddress, ADDR_PULSE_COUNT))
                readData_ff <= {17'h00000, pulseCount};
            else if (hitAddr(avsAddress, ADDR_WAVE_TOP))
                readData_ff <= {17'h00000, activeTop};
            else
                readData_ff <= READ_UNMAPPED;
        end
    end

    assign avsReadData = readData_ff;

    ////////////////////////////////////////////////////////////////////////
    pwmcc_counter uCounter (
        .clk                 (clk),
        .resetn              (resetn),
        .runEn               (moduleOn_ff), // [R05]
        .tick                (countTick),
        .countDirection      (countDir_ff),
        .topValue            (activeTop),
        .count               (pulseCount),
        .periodBoundaryEvent (periodPulse)
    );

    assign moduleOn            = moduleOn_ff;
    assign countDirection      = countDir_ff;
    assign decoderLoad         = decoderLoad_ff;
    assign periodBoundaryEvent = periodPulse;
endmodule : pwmcc_top
`default_nettype wire

/* tb/pwmcc_top_chk.sv */
/*
 pwmcc_top_chk: port assertions for pwmcc_top.
 assumes: bound into pwmcc_top by the bench; one clock, resetn async low.
*/
`timescale 1ns/1ps
`default_nettype none
module pwmcc_top_chk
    import pwmcc_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 avsRead,
    input wire logic                 avsWrite,
    input wire logic [31:0]          avsReadData,
    input wire logic                 avsWaitRequest,
    input wire logic                 countTick,
    input wire logic [CNT_WIDTH-1:0] waveTopValue,
    input wire logic                 moduleOn,
    input wire logic                 countDirection,
    input wire logic [1:0]           decoderLoad,
    input wire logic [CNT_WIDTH-1:0] pulseCount,
    input wire logic                 periodBoundaryEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    sequence sTaken;
        (avsRead || avsWrite) && avsWaitRequest;
    endsequence
    sequence sAnswer;
        !avsWaitRequest ##1 avsWaitRequest;
    endsequence
    // only the four-slot top is visible at the ports, so step checks use it
    sequence sUpTick;
        moduleOn && countTick && countDirection == DIR_UP && decoderLoad == LOAD_FOUR_SLOT;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_bus_answer: assert property (sTaken |=> sAnswer) else $error("bus answer not one cycle");
    a_idle_wait: assert property (!avsRead && !avsWrite |=> avsWaitRequest) else $error("wait low when idle");
    a_data_stands: assert property (!avsRead |=> $stable(avsReadData)) else $error("read data moved");
    a_count_off: assert property (!moduleOn |=> pulseCount == 15'h0000) else $error("count kept when off");
    a_tick_hold: assert property (moduleOn && !countTick |=> $stable(pulseCount)) else $error("count moved");
    a_up_step: assert property (
        sUpTick ##0 pulseCount < waveTopValue |=> pulseCount == $past(pulseCount) + 1)
        else $error("up step wrong");
    a_up_wrap: assert property (
        sUpTick ##0 pulseCount >= waveTopValue |=> pulseCount == 15'h0000 ##[0:1] periodBoundaryEvent)
        else $error("wrap wrong");
    a_event_cause: assert property (
        periodBoundaryEvent |-> $past(countTick) || $past(countTick, 2))
        else $error("event without tick");
endmodule : pwmcc_top_chk
`default_nettype wire

/* tb/tb.sv */
/*
 tb: register, interrupt and counter tests for pwmcc_top.
 assumes: pwmcc_pkg and pwmcc_top_chk compiled first; 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pwmcc_pkg::*;
    logic                 clk = 1'b0;
    logic                 resetn = 1'b0;
    logic [11:0]          avsAddress = 12'h000;
    logic                 avsRead = 1'b0;
    logic                 avsWrite = 1'b0;
    logic [31:0]          avsWriteData = 32'h00000000;
    logic [3:0]           avsByteEnable = 4'hF;
    logic                 countTick = 1'b0;
    logic                 haltDoneEvent = 1'b0;
    logic [1:0]           sequenceBegunEvent = 2'h0;
    logic [1:0]           sequenceFinishedEvent = 2'h0;
    logic                 loopCountExhaustedEvent = 1'b0;
    logic [CNT_WIDTH-1:0] waveTopValue = 15'h0002;
    logic [31:0]          avsReadData;
    logic                 avsWaitRequest;
    logic                 moduleOn;
    logic                 countDirection;
    logic [1:0]           decoderLoad;
    logic [CNT_WIDTH-1:0] pulseCount;
    logic                 periodBoundaryEvent;
    logic                 irq;
    logic [7:0]           mask;
    int                   mismatches = 0;
    int                   checkCount = 0;
    int                   cycles = 0;
    int                   periodEvents = 0;
    ////////////////////////////////////////////////////////////////////////
    pwmcc_top dut (.clk(clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .countTick(countTick), .haltDoneEvent(haltDoneEvent),
        .sequenceBegunEvent(sequenceBegunEvent), .sequenceFinishedEvent(sequenceFinishedEvent),
        .loopCountExhaustedEvent(loopCountExhaustedEvent), .waveTopValue(waveTopValue), .moduleOn(moduleOn),
        .countDirection(countDirection), .decoderLoad(decoderLoad), .pulseCount(pulseCount),
        .periodBoundaryEvent(periodBoundaryEvent), .irq(irq));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task results;
        begin
            $display("mismatches %0d of %0d checks", mismatches, checkCount);
            if (mismatches == 0 && checkCount > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask : results
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checkCount++;
            if (seen !== exp)
            begin
                mismatches++;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask : chk
    // waits on the settled level between edges; the next rising edge completes
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        begin
            n = 0;
            @(posedge clk);
            avsAddress <= a;
            avsWrite <= w;
            avsRead <= !w;
            avsWriteData <= d;
            @(negedge clk);
            while (avsWaitRequest !== 1'b0 && n < 50)
            begin
                n++;
                @(negedge clk);
            end
            if (n >= 50)
                mismatches++;
            // read data cannot move at the completing edge, only at capture
            @(posedge clk);
            q = avsReadData;
            avsRead <= 1'b0;
            avsWrite <= 1'b0;
        end
    endtask : xfer
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        begin
            xfer(1'b1, a, d, q);
            @(negedge clk);
        end
    endtask : wr
    task rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        begin
            xfer(1'b0, a, 32'h00000000, q);
            chk(q, e);
            @(negedge clk);
        end
    endtask : rdc
    task tick(input int n);
        begin
            repeat (n)
            begin
                @(posedge clk);
                countTick <= 1'b1;
                @(posedge clk);
                countTick <= 1'b0;
            end
            @(posedge clk);
            @(negedge clk);
        end
    endtask : tick
    task pulse;
        begin
            @(posedge clk);
            {haltDoneEvent, sequenceBegunEvent, sequenceFinishedEvent, loopCountExhaustedEvent} <= 6'h3F;
            @(posedge clk);
            {haltDoneEvent, sequenceBegunEvent, sequenceFinishedEvent, loopCountExhaustedEvent} <= 6'h00;
            @(negedge clk);
        end
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles++;
        if (periodBoundaryEvent === 1'b1)
            periodEvents++;
        if (cycles == 3000)
        begin
            mismatches++;
            results();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk(irq, 32'h0);
        rdc(ADDR_IRQ_MASK_CLEAR, 32'h00000000);
        rdc(ADDR_MODULE_ON, 32'h00000000);
        rdc(ADDR_COUNT_DIR_SEL, 32'h00000000);
        rdc(ADDR_WRAP_LIMIT, 32'h000003FF);
        rdc(12'h400, READ_UNMAPPED);
        wr(ADDR_IRQ_MASK_SET, 32'h000000FE);
        mask = 8'hFE;
        for (int i = 1; i < 8; i++)
        begin
            wr(ADDR_IRQ_MASK_CLEAR, 32'h00000000);
            wr(ADDR_IRQ_MASK_CLEAR, 32'h00000001 << i);
            mask[i] = 1'b0;
            rdc(ADDR_IRQ_MASK_CLEAR, {24'h000000, mask});
        end
        wr(ADDR_IRQ_MASK_SET, 32'h00000002);
        pulse();
        chk(irq, 32'h1);
        rdc(ADDR_IRQ_STATUS, 32'h000000BE);
        wr(ADDR_IRQ_MASK_CLEAR, 32'h00000002);
        chk(irq, 32'h0);
        wr(ADDR_IRQ_MASK_SET, 32'h00000002);
        chk(irq, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h000000FE);
        chk(irq, 32'h0);
        // only 15 bits of the wrap limit are stored
        wr(ADDR_WRAP_LIMIT, 32'hFFFFFFFF);
        rdc(ADDR_WRAP_LIMIT, 32'h00007FFF);
        // register top 3 differs from the wave top 2, so the source shows
        wr(ADDR_WRAP_LIMIT, 32'h00000003);
        wr(ADDR_MODULE_ON, 32'h00000001);
        rdc(ADDR_MODULE_ON, 32'h00000001);
        chk(moduleOn, 32'h1);
        chk(countDirection, 32'h0);
        rdc(ADDR_WAVE_TOP, 32'h00000003);
        tick(3);
        chk(pulseCount, 32'h3);
        tick(1);
        chk(pulseCount, 32'h0);
        chk(periodEvents, 32'h1);
        rdc(ADDR_IRQ_STATUS, 32'h00000040);
        wr(ADDR_MODULE_ON, 32'h00000000);
        chk(moduleOn, 32'h0);
        wr(ADDR_COUNT_DIR_SEL, {31'h0, DIR_UP_DOWN});
        rdc(ADDR_COUNT_DIR_SEL, 32'h00000001);
        chk(countDirection, 32'h1);
        chk(pulseCount, 32'h0);
        wr(ADDR_MODULE_ON, 32'h00000001);
        tick(4);
        chk(pulseCount, 32'h2);
        tick(2);
        chk(pulseCount, 32'h0);
        chk(periodEvents, 32'h2);
        wr(ADDR_MODULE_ON, 32'h00000000);
        wr(ADDR_COUNT_DIR_SEL, {31'h0, DIR_UP});
        wr(ADDR_DECODER_LOAD, {30'h0, LOAD_FOUR_SLOT});
        chk(decoderLoad, {30'h0, LOAD_FOUR_SLOT});
        wr(ADDR_MODULE_ON, 32'h00000001);
        rdc(ADDR_WAVE_TOP, 32'h00000002);
        tick(2);
        chk(pulseCount, 32'h2);
        tick(1);
        chk(pulseCount, 32'h0);
        chk(periodEvents, 32'h3);
        // mid-run reset while counting: every setting returns to its reset value
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk(moduleOn, 32'h0);
        chk(countDirection, 32'h0);
        chk(pulseCount, 32'h0);
        chk(irq, 32'h0);
        rdc(ADDR_WRAP_LIMIT, 32'h000003FF);
        rdc(ADDR_WAVE_TOP, 32'h000003FF);
        results();
    end
endmodule : tb
bind pwmcc_top pwmcc_top_chk chk (.clk(clk), .resetn(resetn), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .countTick(countTick),
    .waveTopValue(waveTopValue), .moduleOn(moduleOn), .countDirection(countDirection),
    .decoderLoad(decoderLoad), .pulseCount(pulseCount), .periodBoundaryEvent(periodBoundaryEvent));
`default_nettype wire
